// ### verilog/ccd_pkg.sv
// Package: register map, field positions, reset values and divider decode
`default_nettype none
package ccd_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [9:0] ADDR_CHAN_PHASE = 10'h19A;
  localparam logic [9:0] ADDR_CHAN_CTRL = 10'h19B;
  localparam logic [9:0] ADDR_IN_RATIO = 10'h1E0;
  localparam logic [9:0] ADDR_IN_CTRL = 10'h1E1;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int PH_BYPASS = 7;
  localparam int PH_IGNORE_SYNC = 6;
  localparam int PH_FORCE_HIGH = 5;
  localparam int PH_START_HIGH = 4;
  localparam int PH_OFFSET_LSB = 0;
  localparam int CC_POWER_DOWN = 2;
  localparam int CC_DIRECT = 1;
  localparam int CC_DCC_DISABLE = 0;
  localparam int IC_POWER_DOWN = 4;
  localparam int IC_BYPASS = 0;

  // ----------------------------------------
  // Reset values and writable masks
  // ----------------------------------------
  localparam logic [7:0] RST_CHAN_PHASE = 8'h00;
  localparam logic [7:0] RST_CHAN_CTRL = 8'h00;
  localparam logic [7:0] RST_IN_RATIO = 8'h00;
  localparam logic [7:0] RST_IN_CTRL = 8'h00;
  localparam logic [7:0] MASK_CHAN_PHASE = 8'hFF;
  localparam logic [7:0] MASK_CHAN_CTRL = 8'h07;
  localparam logic [7:0] MASK_IN_RATIO = 8'h07;
  localparam logic [7:0] MASK_IN_CTRL = 8'h11;

  // ----------------------------------------
  // Input divider codes
  // ----------------------------------------
  localparam logic [2:0] DIV_CODE_BYPASS = 3'h6;

  // Divide value for a ratio code; zero marks a static output
  function automatic logic [2:0] ccd_div_value(input logic [2:0] code);
    unique case (code)
      3'h0: ccd_div_value = 3'h2;
      3'h1: ccd_div_value = 3'h3;
      3'h2: ccd_div_value = 3'h4;
      3'h3: ccd_div_value = 3'h5;
      3'h4: ccd_div_value = 3'h6;
      DIV_CODE_BYPASS: ccd_div_value = 3'h1;
      default: ccd_div_value = 3'h0;
    endcase
  endfunction : ccd_div_value
endpackage : ccd_pkg
`default_nettype wire

// ### verilog/ccd_in_divider.sv
// Input clock divider: turns input clock ticks into divided ticks
`timescale 1ns/1ps
`default_nettype none
module ccd_in_divider
  import ccd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Input clock edge marker
  input wire logic inTick,
  // Settings
  input wire logic [2:0] ratioCode,
  input wire logic bypass,
  input wire logic powerDown,
  // Divided clock ticks
  output logic divTick
);
  logic [2:0] cnt_q, cnt_d;
  logic divTick_d;
  logic [2:0] divVal;

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  always_comb
  begin
    divVal = ccd_div_value(ratioCode);
    cnt_d = cnt_q;
    divTick_d = 1'b0;
    if (powerDown)
    begin
      cnt_d = 3'h0;
    end
    else if (bypass)
    begin
      divTick_d = inTick;
      cnt_d = 3'h0;
    end
    else if (divVal == 3'h0)
    begin
      cnt_d = 3'h0;
    end
    else if (inTick)
    begin
      // Counter keeps its count across a ratio change, so a wrong-length first period is possible
      if (cnt_q + 3'h1 >= divVal)
      begin
        cnt_d = 3'h0;
        divTick_d = 1'b1;
      end
      else
      begin
        cnt_d = cnt_q + 3'h1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cnt_q <= 3'h0;
      divTick <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      divTick <= divTick_d;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  div_static_a: assert property ((ccd_div_value(ratioCode) == 3'h0) && !bypass
    |=> !divTick) else $error("divided tick in static mode");
  div_pd_a: assert property (powerDown |=> !divTick)
    else $error("divided tick while powered down");
  div_bypass_a: assert property (bypass && !powerDown |=> divTick == $past(inTick))
    else $error("bypass does not pass ticks");
  // A divided tick leaves the counter at zero, so at divide by two the very next input tick must not fire
  div_two_a: assert property (!bypass && !powerDown && ratioCode == 3'h0
    && divTick && inTick |=> !divTick) else $error("divide by two ticks too early");
  div_tick_c: cover property (!bypass && divTick);
endmodule : ccd_in_divider
`default_nettype wire

// ### verilog/ccd_top.sv
// Channel three divider and clock input configuration logic
// Function
// - Force control holds divider output low, or at start level when set.
// - Start-level control picks whether the divider output begins low or high.
// - Four-bit phase offset field is passed out on chanPhaseOffset, not used by the divider, resets to zero.
// - Channel power-down puts all three outputs into safe power-down.
// - Direct-to-output routes input clock to outputs unless input divider bypassed.
// - Duty-cycle correction is on unless its disable control is set.
// - Input divider bypass routes the clock around the input divider.
// - Input power-down stops the whole clock input section.
`timescale 1ns/1ps
`default_nettype none
module ccd_top
  import ccd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register port from the serial control port
  input wire logic [9:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  // Input clock
  input wire logic inClkLevel,
  input wire logic inClkTick,
  // Channel outputs
  output logic channelThreeOutputA,
  output logic channelThreeOutputB,
  output logic channelThreeOutputC,
  output logic chanSafePowerDown,
  // Decoded settings
  output logic dutyCycleCorrectionEn,
  output logic [3:0] chanPhaseOffset,
  output logic inSectionPowerDown
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] chanPhase_q, chanPhase_d;
  logic [7:0] chanCtrl_q, chanCtrl_d;
  logic [7:0] inRatio_q, inRatio_d;
  logic [7:0] inCtrl_q, inCtrl_d;
  logic [7:0] regRdData_d;

  always_comb
  begin
    chanPhase_d = chanPhase_q;
    chanCtrl_d = chanCtrl_q;
    inRatio_d = inRatio_q;
    inCtrl_d = inCtrl_q;
    regRdData_d = regRdData;
    if (regWrEn)
    begin
      unique case (regAddr)
        ADDR_CHAN_PHASE: chanPhase_d = regWrData & MASK_CHAN_PHASE;
        ADDR_CHAN_CTRL: chanCtrl_d = regWrData & MASK_CHAN_CTRL;
        ADDR_IN_RATIO: inRatio_d = regWrData & MASK_IN_RATIO;
        ADDR_IN_CTRL: inCtrl_d = regWrData & MASK_IN_CTRL;
        default: ;
      endcase
    end
    if (regRdEn)
    begin
      // Unused bits and unmapped offsets read as zero
      unique case (regAddr)
        ADDR_CHAN_PHASE: regRdData_d = chanPhase_q;
        ADDR_CHAN_CTRL: regRdData_d = chanCtrl_q;
        ADDR_IN_RATIO: regRdData_d = inRatio_q;
        ADDR_IN_CTRL: regRdData_d = inCtrl_q;
        default: regRdData_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      chanPhase_q <= RST_CHAN_PHASE;
      chanCtrl_q <= RST_CHAN_CTRL;
      inRatio_q <= RST_IN_RATIO;
      inCtrl_q <= RST_IN_CTRL;
      regRdData <= 8'h00;
    end
    else
    begin
      chanPhase_q <= chanPhase_d;
      chanCtrl_q <= chanCtrl_d;
      inRatio_q <= inRatio_d;
      inCtrl_q <= inCtrl_d;
      regRdData <= regRdData_d;
    end
  end

  // ----------------------------------------
  // Input divider
  // ----------------------------------------
  logic divTick;
  logic inPd;
  logic inBypass;

  assign inPd = inCtrl_q[IC_POWER_DOWN];
  assign inBypass = inCtrl_q[IC_BYPASS];

  ccd_in_divider u_in_divider (
    .clk(clk),
    .srst(srst),
    .inTick(inClkTick),
    .ratioCode(inRatio_q[2:0]),
    .bypass(inBypass),
    .powerDown(inPd),
    .divTick(divTick)
  );

  // ----------------------------------------
  // Channel divider and output routing
  // ----------------------------------------
  logic chanLevel_q, chanLevel_d;
  logic outLevel_d;
  logic forceActive;
  logic chanPd;
  logic directRoute;

  // Force only bites when sync is ignored and the channel divider is in use
  assign forceActive = chanPhase_q[PH_IGNORE_SYNC] && !chanPhase_q[PH_BYPASS];
  assign chanPd = chanCtrl_q[CC_POWER_DOWN];
  assign directRoute = chanCtrl_q[CC_DIRECT] && !inBypass;

  always_comb
  begin
    chanLevel_d = chanLevel_q;
    if (chanPd || inPd)
    begin
      chanLevel_d = chanPhase_q[PH_START_HIGH];
    end
    else if (forceActive)
    begin
      // Forced value; start level also primes the restart once force is released
      chanLevel_d = chanPhase_q[PH_FORCE_HIGH] & chanPhase_q[PH_START_HIGH];
    end
    else if (divTick)
    begin
      chanLevel_d = !chanLevel_q;
    end
    if (chanPd || inPd)
    begin
      outLevel_d = 1'b0;
    end
    else if (directRoute)
    begin
      outLevel_d = inClkLevel;
    end
    else
    begin
      outLevel_d = chanLevel_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      chanLevel_q <= 1'b0;
      channelThreeOutputA <= 1'b0;
      channelThreeOutputB <= 1'b0;
      channelThreeOutputC <= 1'b0;
      chanSafePowerDown <= 1'b0;
      dutyCycleCorrectionEn <= 1'b1;
      chanPhaseOffset <= 4'h0;
      inSectionPowerDown <= 1'b0;
    end
    else
    begin
      chanLevel_q <= chanLevel_d;
      channelThreeOutputA <= outLevel_d;
      channelThreeOutputB <= outLevel_d;
      channelThreeOutputC <= outLevel_d;
      chanSafePowerDown <= chanPd;
      dutyCycleCorrectionEn <= !chanCtrl_q[CC_DCC_DISABLE];
      chanPhaseOffset <= chanPhase_q[PH_OFFSET_LSB +: 4];
      inSectionPowerDown <= inPd;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  force_low_a: assert property (forceActive && !chanPhase_q[PH_FORCE_HIGH]
    && !chanPd && !inPd && !directRoute |=> !channelThreeOutputA)
    else $error("forced low not held");
  force_start_a: assert property (forceActive && chanPhase_q[PH_FORCE_HIGH]
    && !chanPd && !inPd && !directRoute
    |=> channelThreeOutputA == $past(chanPhase_q[PH_START_HIGH]))
    else $error("forced level differs from start level");
  force_bypass_a: assert property (chanPhase_q[PH_BYPASS] && divTick
    && !chanPd && !inPd |=> chanLevel_q != $past(chanLevel_q))
    else $error("force applied while divider bypassed");
  start_level_a: assert property ((chanPd || inPd) ##1 !(chanPd || inPd)
    && !divTick && !forceActive |=> chanLevel_q == $past(chanPhase_q[PH_START_HIGH], 2))
    else $error("divider did not start at start level");
  phase_out_a: assert property (regWrEn && regAddr == ADDR_CHAN_PHASE
    |=> ##1 chanPhaseOffset == $past(regWrData[3:0], 2))
    else $error("phase offset lost");
  pd_outputs_a: assert property (chanPd |=> !channelThreeOutputA
    && !channelThreeOutputB && !channelThreeOutputC && chanSafePowerDown)
    else $error("power-down leak");
  direct_route_a: assert property (directRoute && !chanPd && !inPd
    |=> channelThreeOutputB == $past(inClkLevel))
    else $error("direct route broken");
  direct_bypass_a: assert property (chanCtrl_q[CC_DIRECT] && inBypass
    && !chanPd && !inPd |=> channelThreeOutputA == chanLevel_q)
    else $error("direct route not blocked by bypass");
  dcc_en_a: assert property (chanCtrl_q[CC_DCC_DISABLE] |=> !dutyCycleCorrectionEn)
    else $error("correction not disabled");
  in_pd_a: assert property (inPd |=> inSectionPowerDown && !channelThreeOutputC)
    else $error("input power-down not applied");
  outs_equal_a: assert property (channelThreeOutputA == channelThreeOutputB
    && channelThreeOutputB == channelThreeOutputC) else $error("channel outputs differ");

  direct_c: cover property (directRoute && !chanPd ##1 channelThreeOutputA);
  force_c: cover property (forceActive && chanPhase_q[PH_FORCE_HIGH]);
  toggle_c: cover property (!directRoute && $rose(channelThreeOutputA));
endmodule : ccd_top
`default_nettype wire

// ### verilog/ccd_fix_note.sv
// Spare source slot: holds no code

// ### verif/ccd_tb.sv
// Self-checking testbench for the channel three divider configuration block
`timescale 1ns/1ps
`default_nettype none
module tb
  import ccd_pkg::*;
;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [9:0] regAddr = 10'h000;
  logic [7:0] regWrData = 8'h00;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic inClkLevel = 1'b0;
  logic inClkTick = 1'b0;
  logic [7:0] regRdData;
  logic outA, outB, outC, safePd, dccEn, inPd;
  logic [3:0] phase;
  int badCount = 0;
  int compares = 0;

  always #12.5 clk = ~clk;

  ccd_top u_dut (.clk(clk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .inClkLevel(inClkLevel),
    .inClkTick(inClkTick), .channelThreeOutputA(outA), .channelThreeOutputB(outB),
    .channelThreeOutputC(outC), .chanSafePowerDown(safePd), .dutyCycleCorrectionEn(dccEn),
    .chanPhaseOffset(phase), .inSectionPowerDown(inPd));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      badCount++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
  endtask : wr

  task automatic rd(input logic [9:0] a, input logic [7:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    #1;
    chk("read data", exp, regRdData);
  endtask : rd

  // Effects land two edges after the write; one more keeps clear of races
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask : settle

  // Counts output changes over 60 cycles; 60 is a multiple of every divide value
  task automatic toggles(input logic [7:0] exp);
    int n;
    logic prev;
    n = 0;
    prev = outA;
    repeat (60)
    begin
      @(posedge clk);
      #1;
      if (outA !== prev) n++;
      prev = outA;
      chk("outputs b c", {6'h00, outA, outA}, {6'h00, outB, outC});
    end
    chk("toggle count", exp, 8'(n));
  endtask : toggles

  task automatic wrapUp();
    $display("comparisons %0d mismatches %0d", compares, badCount);
    if (badCount == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrapUp

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd(ADDR_CHAN_PHASE, 8'h00);
    rd(ADDR_CHAN_CTRL, 8'h00);
    rd(ADDR_IN_RATIO, 8'h00);
    rd(ADDR_IN_CTRL, 8'h00);
    chk("dcc enable", 8'h01, {7'h00, dccEn});
    chk("phase offset", 8'h00, {4'h0, phase});
    chk("power flags", 8'h00, {6'h00, safePd, inPd});
    $display("done reset test");
  endtask : t_reset

  task automatic t_map();
    wr(ADDR_CHAN_PHASE, 8'hFF);
    wr(ADDR_CHAN_CTRL, 8'hFF);
    wr(ADDR_IN_RATIO, 8'hFF);
    wr(ADDR_IN_CTRL, 8'hFF);
    wr(10'h100, 8'hFF);
    settle();
    chk("safe power down", 8'h01, {7'h00, safePd});
    chk("input power down", 8'h01, {7'h00, inPd});
    chk("dcc enable", 8'h00, {7'h00, dccEn});
    chk("phase offset", 8'h0F, {4'h0, phase});
    chk("outputs", 8'h00, {5'h00, outA, outB, outC});
    rd(ADDR_CHAN_PHASE, 8'hFF);
    rd(ADDR_CHAN_CTRL, MASK_CHAN_CTRL);
    rd(ADDR_IN_RATIO, MASK_IN_RATIO);
    rd(ADDR_IN_CTRL, MASK_IN_CTRL);
    rd(10'h100, 8'h00);
    wr(ADDR_CHAN_PHASE, 8'h0A);
    wr(ADDR_CHAN_CTRL, 8'h00);
    wr(ADDR_IN_RATIO, 8'h00);
    wr(ADDR_IN_CTRL, 8'h00);
    settle();
    chk("phase offset", 8'h0A, {4'h0, phase});
    chk("dcc enable", 8'h01, {7'h00, dccEn});
    chk("power flags", 8'h00, {6'h00, safePd, inPd});
    $display("done register map test");
  endtask : t_map

  task automatic t_force();
    @(posedge clk);
    inClkTick <= 1'b1;
    wr(ADDR_CHAN_PHASE, 8'h70);
    settle();
    chk("forced start level", 8'h01, {7'h00, outA});
    wr(ADDR_CHAN_PHASE, 8'h60);
    settle();
    chk("forced low", 8'h00, {7'h00, outA});
    wr(ADDR_CHAN_PHASE, 8'h50);
    settle();
    toggles(8'h00);
    chk("force low start high", 8'h00, {7'h00, outA});
    // Channel divider bypassed: force is ignored and the level keeps toggling
    wr(ADDR_CHAN_PHASE, 8'hE0);
    settle();
    toggles(8'd30);
    @(posedge clk);
    inClkTick <= 1'b0;
    wr(ADDR_CHAN_PHASE, 8'h10);
    wr(ADDR_CHAN_CTRL, 8'h04);
    settle();
    chk("powered down", 8'h00, {7'h00, outA});
    wr(ADDR_CHAN_CTRL, 8'h00);
    settle();
    chk("start high", 8'h01, {7'h00, outA});
    wr(ADDR_CHAN_PHASE, 8'h00);
    wr(ADDR_CHAN_CTRL, 8'h04);
    wr(ADDR_CHAN_CTRL, 8'h00);
    settle();
    chk("start low", 8'h00, {7'h00, outA});
    $display("done force and start test");
  endtask : t_force

  task automatic t_direct();
    wr(ADDR_CHAN_CTRL, 8'h02);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk);
      inClkLevel <= ~i[0];
      settle();
      chk("direct route", {7'h00, ~i[0]}, {7'h00, outA});
    end
    // Input level is high and the idle divider level low: only a live direct route reads 1
    wr(ADDR_IN_CTRL, 8'h01);
    settle();
    chk("direct with bypass", 8'h00, {7'h00, outA});
    wr(ADDR_CHAN_CTRL, 8'h00);
    wr(ADDR_IN_CTRL, 8'h00);
    $display("done direct route test");
  endtask : t_direct

  task automatic t_ratio();
    logic [7:0] divs [8] = '{8'd2, 8'd3, 8'd4, 8'd5, 8'd6, 8'd0, 8'd1, 8'd0};
    @(posedge clk);
    inClkTick <= 1'b1;
    for (int c = 0; c < 8; c++)
    begin
      wr(ADDR_IN_RATIO, 8'(c));
      settle();
      toggles((divs[c] == 8'd0) ? 8'd0 : 8'd60 / divs[c]);
    end
    wr(ADDR_IN_RATIO, 8'h01);
    wr(ADDR_IN_CTRL, 8'h01);
    settle();
    toggles(8'd60);
    wr(ADDR_IN_CTRL, 8'h10);
    settle();
    chk("input power down", 8'h01, {7'h00, inPd});
    toggles(8'd0);
    chk("outputs off", 8'h00, {7'h00, outA});
    wr(ADDR_IN_CTRL, 8'h00);
    settle();
    toggles(8'd20);
    @(posedge clk);
    inClkTick <= 1'b0;
    $display("done divider ratio test");
  endtask : t_ratio

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_map();
    t_force();
    t_direct();
    t_ratio();
    wrapUp();
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    badCount++;
    wrapUp();
  end
endmodule : tb
`default_nettype wire
